// File: shared/dsr_pkg.sv
// Purpose: Constants for the dual converter serial readout control
// Assumes: Strobe and shift clock sampled synchronously on clk
// Notes on behaviour
// - Results are straight binary, 4096 code steps.
// - Three power modes chosen by strobe rise.
// - Rise in edges 10..13: stay powered, abort.
// - Fourteen shift cycles complete one result.
// - After fourteen, shifting goes on until edge 32 or rise.
// - Two further cycles give two trailing zeros.
// - Further fourteen cycles give other converter result.
// - Line tri-states at edge 32 or rise.
// - Rise in edges 2..9 enters partial power-down.
// - Rise before edge 2 ignored in normal.
// - Partial power-down keeps only reference powered.
// - Dummy conversion wakes from partial power-down.
// - Early rise in partial returns to partial.
// - Rise in edges 2..9 from partial: full.
// - Full power-down switches off reference too.
// - Zero, zero, then twelve bits; last at 14.
package dsr_pkg;
    localparam int unsigned DSR_RES_BITS   = 12;
    localparam int unsigned DSR_EDGE_GLITCH = 2;
    localparam int unsigned DSR_EDGE_KEEP  = 10;
    localparam int unsigned DSR_EDGE_ONE   = 14;
    localparam int unsigned DSR_EDGE_TRAIL = 16;
    localparam int unsigned DSR_EDGE_END   = 32;
    localparam int unsigned DSR_CNT_W      = 6;
    localparam int unsigned DSR_CLK_NS     = 10;
    localparam int unsigned DSR_WAKE_NS    = 333;
    localparam int unsigned DSR_WAKE_CYC   =
        (DSR_WAKE_NS + DSR_CLK_NS - 1) / DSR_CLK_NS;

    typedef enum logic [2:0] {
        DSR_NORMAL  = 3'h1,
        DSR_PARTIAL = 3'h2,
        DSR_FULL    = 3'h4
    } dsr_power_type;
endpackage : dsr_pkg

// File: core/dsr_readout.sv
// Purpose: Power mode and serial result control of a dual converter
// Assumes: sample_strobe_n and shift_clk synchronous to clk
// Notes: Results arrive from the analog core as 12-bit binary codes
`timescale 1ns/10ps
module dsr_readout
    import dsr_pkg::*;
#(
    parameter int unsigned RES_BITS = dsr_pkg::DSR_RES_BITS
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // Host serial pins
    input  wire logic                  sample_strobe_n,
    input  wire logic                  shift_clk,
    output logic                       result_line_a,
    output logic                       result_line_a_oe,
    output logic                       result_line_b,
    output logic                       result_line_b_oe,
    // Analog core
    input  wire logic [RES_BITS-1:0]   code_a,
    input  wire logic [RES_BITS-1:0]   code_b,
    output logic                       hold_sample,
    output logic                       analog_on,
    output logic                       reference_on,
    output dsr_pkg::dsr_power_type     power_mode
);
    import dsr_pkg::*;

    // Frame layout and counters are sized for 12-bit codes only
    if (RES_BITS != DSR_RES_BITS) begin : g_bad_width
        $error("dsr_readout: only 12-bit results are served");
    end

    typedef struct packed {
        dsr_power_type              mode;
        logic                       strobe_d;
        logic                       sclk_d;
        logic                       active;
        logic [DSR_CNT_W-1:0]       edges;
        logic [2*DSR_EDGE_TRAIL-1:0] shreg_a;
        logic [2*DSR_EDGE_TRAIL-1:0] shreg_b;
        logic                       oe;
        logic                       hold;
        logic                       analog;
        logic                       refon;
    } dsr_state_type;

    dsr_state_type st;
    dsr_state_type next_st;

    // Frame: 2 leading zeros, 12 bits, 2 trailing zeros
    function automatic logic [DSR_EDGE_TRAIL-1:0] frame16(
        input logic [RES_BITS-1:0] code
    );
        frame16 = {2'h0, code, 2'h0};
    endfunction : frame16

    always_comb begin
        logic fall_strobe;
        logic rise_strobe;
        logic fall_sclk;
        fall_strobe = 1'b0;
        rise_strobe = 1'b0;
        fall_sclk   = 1'b0;
        next_st = st;
        next_st.strobe_d = sample_strobe_n;
        next_st.sclk_d   = shift_clk;
        fall_strobe = st.strobe_d && !sample_strobe_n;
        rise_strobe = !st.strobe_d && sample_strobe_n;
        fall_sclk   = st.sclk_d && !shift_clk;

        if (fall_strobe) begin
            next_st.active  = 1'b1;
            next_st.edges   = '0;
            next_st.oe      = 1'b1;
            next_st.hold    = 1'b1;
            // A then B on line a
            next_st.shreg_a = {frame16(code_a), frame16(code_b)};
            next_st.shreg_b = {frame16(code_b), frame16(code_a)};
            // power up begins at strobe fall
            next_st.analog  = 1'b1;
            next_st.refon   = 1'b1;
        end else if (rise_strobe && st.active) begin
            next_st.active = 1'b0;
            next_st.oe     = 1'b0;
            next_st.hold   = 1'b0;
            if (st.edges < DSR_CNT_W'(DSR_EDGE_GLITCH)) begin
                next_st.mode = st.mode;
            end else if (st.edges < DSR_CNT_W'(DSR_EDGE_KEEP)) begin
                next_st.mode = (st.mode == DSR_NORMAL) ?
                    DSR_PARTIAL : DSR_FULL;
            end else begin
                next_st.mode = DSR_NORMAL;
            end
            next_st.analog = (next_st.mode == DSR_NORMAL);
            next_st.refon  = (next_st.mode != DSR_FULL);
        end else if (fall_sclk && st.active &&
                     st.edges < DSR_CNT_W'(DSR_EDGE_END)) begin
            // shift one bit per falling edge
            next_st.edges   = st.edges + DSR_CNT_W'(1);
            next_st.shreg_a = {st.shreg_a[2*DSR_EDGE_TRAIL-2:0], 1'b0};
            next_st.shreg_b = {st.shreg_b[2*DSR_EDGE_TRAIL-2:0], 1'b0};
            if (st.edges + DSR_CNT_W'(1) == DSR_CNT_W'(DSR_EDGE_ONE - 1)) begin
                next_st.hold = 1'b0;
            end
            if (st.edges + DSR_CNT_W'(1) == DSR_CNT_W'(DSR_EDGE_KEEP)) begin
                next_st.mode = DSR_NORMAL;
            end
            if (st.edges + DSR_CNT_W'(1) == DSR_CNT_W'(DSR_EDGE_END)) begin
                next_st.oe = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st.mode     <= DSR_NORMAL;
            st.strobe_d <= 1'b1;
            st.sclk_d   <= 1'b1;
            st.active   <= 1'b0;
            st.edges    <= '0;
            st.shreg_a  <= '0;
            st.shreg_b  <= '0;
            st.oe       <= 1'b0;
            st.hold     <= 1'b0;
            st.analog   <= 1'b1;
            st.refon    <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign result_line_a    = st.shreg_a[2*DSR_EDGE_TRAIL-1];
    assign result_line_b    = st.shreg_b[2*DSR_EDGE_TRAIL-1];
    assign result_line_a_oe = st.oe;
    // Line b carries B then A; enabled together with line a
    assign result_line_b_oe = st.oe;
    assign hold_sample      = st.hold;
    assign analog_on        = st.analog;
    assign reference_on     = st.refon;
    assign power_mode       = st.mode;
endmodule : dsr_readout

// File: tb/dsr_readout_properties.sv
// Purpose: Port checks of dsr_readout
// Assumes: One clock domain, async low reset
// Notes: Strobe edges may take two clk to act
`timescale 1ns/10ps
module dsr_readout_properties
    import dsr_pkg::*;
(
    // Clock and reset
    input wire logic      clk,
    input wire logic      reset_n,
    // Pins and power
    input wire logic      sample_strobe_n,
    input wire logic      result_line_a,
    input wire logic      result_line_a_oe,
    input wire logic      result_line_b,
    input wire logic      result_line_b_oe,
    input wire logic      hold_sample,
    input wire logic      analog_on,
    input wire logic      reference_on,
    input dsr_pkg::dsr_power_type power_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_start;
        $fell(sample_strobe_n);
    endsequence
    sequence s_open;
        result_line_a_oe && result_line_b_oe
            && !result_line_a && !result_line_b;
    endsequence
    property p_pow(dsr_power_type m, logic pa, logic pr);
        power_mode == m && $stable(power_mode) && sample_strobe_n
            && $past(sample_strobe_n)
            |-> analog_on == pa && reference_on == pr;
    endproperty
    chk_leading_zero: assert property (s_start |-> ##[1:2] s_open)
        else $error("no leading zero");
    chk_sample_hold: assert property (s_start |-> ##[1:2] hold_sample)
        else $error("no hold on strobe fall");
    chk_rise_release: assert property ($rose(sample_strobe_n)
        |-> ##[1:2] !result_line_a_oe && !result_line_b_oe)
        else $error("lines driven after rise");
    chk_oe_pair: assert property (result_line_a_oe == result_line_b_oe)
        else $error("enables differ");
    chk_mode_cause: assert property ($changed(power_mode)
        && power_mode != DSR_NORMAL |-> sample_strobe_n
        && (!$past(sample_strobe_n, 2) || !$past(sample_strobe_n, 3)))
        else $error("mode change without rise");
    chk_partial_pwr: assert property (p_pow(DSR_PARTIAL, 0, 1))
        else $error("partial power wrong");
    chk_full_pwr: assert property (p_pow(DSR_FULL, 0, 0))
        else $error("full power wrong");
    chk_normal_pwr: assert property (p_pow(DSR_NORMAL, 1, 1))
        else $error("normal power wrong");
endmodule : dsr_readout_properties
bind dsr_readout dsr_readout_properties u_chk (.clk, .reset_n,
    .sample_strobe_n, .result_line_a, .result_line_a_oe, .result_line_b,
    .result_line_b_oe, .hold_sample, .analog_on, .reference_on,
    .power_mode);

// File: tb/dsr_host_model.sv
// Purpose: Host serial port model
// Assumes: Tasks are entered at a clk falling edge
// Notes: Bits read just before each shift clock fall
`timescale 1ns/10ps
module dsr_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic     strobe_n = 1'h1,
    output logic     sclk = 1'h1,
    input wire logic wire_a,
    input wire logic wire_b
);
    logic [31:0] got_a;
    logic [31:0] got_b;
    // Long wake wait shortened in bench
    task automatic rise();
        strobe_n = 1'h1;
        repeat (6) @(negedge clk);
    endtask : rise
    task automatic frame(input int n, input int half, input logic up);
        strobe_n = 1'h0;
        for (int i = 0; i < n; i++) begin
            repeat (half) @(negedge clk);
            got_a = {got_a[30:0], wire_a};
            got_b = {got_b[30:0], wire_b};
            sclk = 1'h0;
            repeat (half) @(negedge clk);
            sclk = 1'h1;
        end
        repeat (4) @(negedge clk);
        if (up) begin
            rise();
        end
    endtask : frame
endmodule : dsr_host_model

// File: tb/dsr_readout_tb_top.sv
// Purpose: Bench for dsr_readout
// Assumes: Host model owns strobe and shift clock
// Notes: One code pair across all frames
`timescale 1ns/10ps
module dsr_readout_tb_top;
    import dsr_pkg::*;
    logic clk, reset_n, strobe_n, sclk, la, lb, oa, ob, hold, an, rf, ok;
    logic [11:0] ca = 12'ha5c;
    logic [11:0] cb = 12'h3c1;
    dsr_power_type pm;
    int err_total, samples_checked;
    dsr_readout u_dut (.clk, .reset_n, .sample_strobe_n(strobe_n),
        .shift_clk(sclk), .result_line_a(la), .result_line_a_oe(oa),
        .result_line_b(lb), .result_line_b_oe(ob), .code_a(ca),
        .code_b(cb), .hold_sample(hold), .analog_on(an),
        .reference_on(rf), .power_mode(pm));
    dsr_host_model u_host (.clk, .strobe_n, .sclk,
        .wire_a(oa ? la : ~la), .wire_b(ob ? lb : ~lb));
    task automatic check(input logic good, input string what);
        samples_checked++;
        if (good !== 1'h1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : check
    task automatic t_read();
        u_host.frame(32, 3, 1'h0);
        check(oa === 1'h0 && ob === 1'h0, "oe at 32");
        check(u_host.got_a === {2'h0, ca, 4'h0, cb, 2'h0}, "a");
        check(u_host.got_b === {2'h0, cb, 4'h0, ca, 2'h0}, "b");
        u_host.rise();
        u_host.frame(16, 5, 1'h0);
        check(oa === 1'h1 && u_host.got_a[15:0] === {2'h0, ca, 2'h0}, "16");
        check(hold === 1'h0, "hold");
        u_host.rise();
        check(oa === 1'h0, "rise");
    endtask : t_read
    task automatic t_modes();
        int n[8] = '{1, 12, 5, 1, 5, 10, 5, 10};
        dsr_power_type m[8] = '{DSR_NORMAL, DSR_NORMAL, DSR_PARTIAL,
            DSR_PARTIAL, DSR_FULL, DSR_NORMAL, DSR_PARTIAL, DSR_NORMAL};
        for (int i = 0; i < 8; i++) begin
            u_host.frame(n[i], 2 + i % 3, 1'h1);
            check(pm === m[i] && oa === 1'h0, "mode");
            ok = an === (m[i] == DSR_NORMAL) && rf === (m[i] != DSR_FULL);
            check(ok, "power");
        end
    endtask : t_modes
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        reset_n = 1'h0;
        repeat (10) @(negedge clk);
        reset_n = 1'h1;
        repeat (2) @(negedge clk);
        t_read();
        t_modes();
        finish_test();
    end
    initial begin
        #200us;
        err_total++;
        finish_test();
    end
endmodule : dsr_readout_tb_top
